// file: verilog/srw_sys_ctrl.sv
// Sleep control, clock gating, reset sequencer, supply monitor and watchdog
// Assumes one clock, APB register access, and inputs synchronous to pclk
`timescale 1ns/10ps
`include "srw_cfg.svh"

module srw_sys_ctrl
    import srw_pkg::*;
#(
    parameter int unsigned RESET_TOUT_OSC = `SRW_TOUT_OSC_CYC
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wdt_osc,
    input wire logic por_below,
    input wire logic ext_rst_n,
    input wire logic vlm_below,
    input wire logic reset_pin_disable_fuse,
    input wire logic watchdog_safety_fuse,
    input wire logic sleep_instr,
    input wire logic wdr_instr,
    input wire logic wake_evt,
    input wire logic wdt_irq_ack,
    output logic io_reset_n,
    output logic core_reset_n,
    output logic sleep_active,
    output logic [2:0] sleep_mode_out,
    output logic [2:0] supply_trigger_level,
    output srw_clk_gate_t clk_gate,
    output logic wdt_irq,
    output logic vlm_irq
);

    // ********************************
    // Decode helpers
    // ********************************
    // Word hit on an aligned register index
    function automatic logic reg_hit(input logic [7:0] a, input logic [5:0] idx);
        reg_hit = (a[1:0] == 2'b00) && (a[7:2] == idx);
    endfunction

    // Legal sleep mode codes
    function automatic logic mode_legal(input logic [2:0] m);
        mode_legal = (m == SRW_SL_IDLE) || (m == SRW_SL_NOISE) ||
            (m == SRW_SL_PDOWN) || (m == SRW_SL_STBY);
    endfunction

    // Time-out limit in oscillator cycles, reserved codes clamp to the longest
    function automatic logic [19:0] wdt_limit(input logic [3:0] p);
        logic [3:0] q;
        q = (p > `SRW_WDT_MAXP) ? `SRW_WDT_MAXP : p;
        wdt_limit = 20'((`SRW_WDT_BASE << q) - 32'd1);
    endfunction

    logic [1:0] prr_q;
    logic sleep_mode_control_se_q;
    logic [2:0] sleep_mode_control_sm_q;
    logic sleep_q;
    logic wdif_q, watchdog_irq_enable_q, wde_q;
    logic [3:0] wdp_q;
    logic watchdog_reset_flag_q, extrf_q, power_on_reset_flag_q;
    logic vlm_flag_q, vlm_ie_q;
    logic [2:0] vlm_lvl_q;
    logic [2:0] ccp_win_q;
    logic osc_q, por_q, vlm_below_q;
    logic [19:0] wdt_cnt_q;
    logic [15:0] tout_cnt_q;
    logic wdt_pulse_q;
    logic core_rst_n_q;
    logic [31:0] prdata_q;
    srw_rst_state_t rs_q;
    logic osc_tick, src_active, vlm_rst_act, sys_rst;
    logic mapped, acc, wr_en, wde_eff, wdt_on, wdt_tmo, rst_mode;
    logic wr_wdt, wr_vlm, wr_rstf, prot_ok, vlm_flag_mode;
    logic [31:0] rd_mux;

    // ********************************
    // APB slave
    // ********************************
    assign acc = psel && penable;
    assign mapped = reg_hit(paddr, `SRW_IDX_WDT) || reg_hit(paddr, `SRW_IDX_VLM) ||
        reg_hit(paddr, `SRW_IDX_PRR) || reg_hit(paddr, `SRW_IDX_SLEEP_MODE_CONTROL) ||
        reg_hit(paddr, `SRW_IDX_RSTF) || reg_hit(paddr, `SRW_IDX_CCP);
    assign pready = acc; // Zero wait states
    assign pslverr = acc && !mapped;
    assign wr_en = acc && pwrite && pstrb[0] && mapped;
    assign wr_wdt = wr_en && reg_hit(paddr, `SRW_IDX_WDT);
    assign wr_vlm = wr_en && reg_hit(paddr, `SRW_IDX_VLM);
    assign wr_rstf = wr_en && reg_hit(paddr, `SRW_IDX_RSTF);
    assign prdata = prdata_q;

    // Read multiplexer, reserved bits read zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (reg_hit(paddr, `SRW_IDX_WDT))
            rd_mux[7:0] = {wdif_q, watchdog_irq_enable_q, wdp_q[3], 1'b0, wde_eff, wdp_q[2:0]};
        else if (reg_hit(paddr, `SRW_IDX_VLM))
            rd_mux[7:0] = {vlm_flag_q, vlm_ie_q, 3'b000, vlm_lvl_q};
        else if (reg_hit(paddr, `SRW_IDX_PRR))
            rd_mux[1:0] = prr_q;
        else if (reg_hit(paddr, `SRW_IDX_SLEEP_MODE_CONTROL))
            rd_mux[3:0] = {sleep_mode_control_sm_q, sleep_mode_control_se_q};
        else if (reg_hit(paddr, `SRW_IDX_RSTF))
            rd_mux[3:0] = {watchdog_reset_flag_q, 1'b0, extrf_q, power_on_reset_flag_q};
    end

    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h0000_0000;
        else if (psel && !penable)
            prdata_q <= rd_mux;
    end

    // ********************************
    // Reset sources and sequencer
    // ********************************
    assign vlm_rst_act = vlm_below && (vlm_lvl_q == 3'b001 || vlm_lvl_q == 3'b010);
    assign src_active = por_below || (!ext_rst_n && !reset_pin_disable_fuse) ||
        vlm_rst_act;
    assign sys_rst = (rs_q != SRW_RS_RUN) || wdt_pulse_q;
    assign io_reset_n = presetn && !src_active && !sys_rst;
    assign core_reset_n = core_rst_n_q;
    assign osc_tick = wdt_osc && !osc_q;

    // Input edge history
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            osc_q <= 1'b0;
            por_q <= 1'b0;
            vlm_below_q <= 1'b0;
        end
        else
        begin
            osc_q <= wdt_osc;
            por_q <= por_below;
            vlm_below_q <= vlm_below;
        end
    end

    // Hold, then stretch by the oscillator-counted delay
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rs_q <= SRW_RS_HOLD;
            tout_cnt_q <= 16'h0000;
        end
        else if (src_active)
        begin
            rs_q <= SRW_RS_HOLD;
            tout_cnt_q <= 16'h0000;
        end
        else
        begin
            unique case (rs_q)
                SRW_RS_HOLD:
                begin
                    rs_q <= SRW_RS_DELAY;
                    tout_cnt_q <= 16'h0000;
                end
                SRW_RS_DELAY:
                begin
                    if (osc_tick && tout_cnt_q == 16'(RESET_TOUT_OSC - 1))
                        rs_q <= SRW_RS_RUN;
                    else if (osc_tick)
                        tout_cnt_q <= tout_cnt_q + 16'h0001;
                end
                SRW_RS_RUN:
                begin
                    if (wdt_pulse_q)
                    begin
                        rs_q <= SRW_RS_DELAY;
                        tout_cnt_q <= 16'h0000;
                    end
                end
                default:
                    rs_q <= SRW_RS_HOLD;
            endcase
        end
    end

    // Core held until the delay ends
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            core_rst_n_q <= 1'b0;
        else
            core_rst_n_q <= !sys_rst && !src_active;
    end

    // ********************************
    // Sleep control and clock gating
    // ********************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sleep_mode_control_se_q <= 1'b0;
            sleep_mode_control_sm_q <= 3'b000;
            prr_q <= `SRW_PRR_RST;
        end
        else if (sys_rst)
        begin
            {sleep_mode_control_sm_q, sleep_mode_control_se_q} <= `SRW_SLEEP_MODE_CONTROL_RST;
            prr_q <= `SRW_PRR_RST;
        end
        else if (wr_en && reg_hit(paddr, `SRW_IDX_SLEEP_MODE_CONTROL))
            {sleep_mode_control_sm_q, sleep_mode_control_se_q} <= pwdata[3:0];
        else if (wr_en && reg_hit(paddr, `SRW_IDX_PRR))
            prr_q <= pwdata[1:0];
    end

    // Sleep entry needs the enable bit and a legal mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sleep_q <= 1'b0;
        else if (sys_rst || wake_evt)
            sleep_q <= 1'b0;
        else if (sleep_instr && sleep_mode_control_se_q && mode_legal(sleep_mode_control_sm_q))
            sleep_q <= 1'b1;
    end

    assign sleep_active = sleep_q;
    assign sleep_mode_out = sleep_mode_control_sm_q;
    assign clk_gate.adc_clk_en = !prr_q[1];
    assign clk_gate.cmp_mux_ok = !prr_q[1];
    assign clk_gate.tim_clk_en = !prr_q[0];

    // ********************************
    // Supply monitor
    // ********************************
    assign vlm_flag_mode = (vlm_lvl_q == 3'b011) || (vlm_lvl_q == 3'b100);
    assign supply_trigger_level = vlm_lvl_q;
    assign vlm_irq = vlm_flag_q && vlm_ie_q;

    // Level survives internal resets so a low supply keeps reset held
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            vlm_lvl_q <= 3'b000;
        else if (por_below)
            vlm_lvl_q <= 3'b000;
        else if (wr_vlm)
            vlm_lvl_q <= pwdata[2:0];
    end

    // Flag: set wins over the write clear; internal reset blocks the set and clears
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vlm_flag_q <= 1'b0;
            vlm_ie_q <= 1'b0;
        end
        else if (vlm_flag_mode && vlm_below && !vlm_below_q && !sys_rst)
        begin
            vlm_flag_q <= 1'b1;
            if (wr_vlm)
                vlm_ie_q <= pwdata[`SRW_B_SUPPLY_MONITOR_IRQ_ENABLE];
        end
        else if (sys_rst)
        begin
            vlm_flag_q <= 1'b0;
            vlm_ie_q <= 1'b0;
        end
        else
        begin
            if (!vlm_below || (wr_vlm && (!pwdata[`SRW_B_SUPPLY_MONITOR_FLAG] ||
                pwdata[2:0] != vlm_lvl_q)))
                vlm_flag_q <= 1'b0;
            if (wr_vlm)
                vlm_ie_q <= pwdata[`SRW_B_SUPPLY_MONITOR_IRQ_ENABLE];
        end
    end

    // ********************************
    // Reset flags
    // ********************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            power_on_reset_flag_q <= 1'b1;
            extrf_q <= 1'b0;
            watchdog_reset_flag_q <= 1'b0;
        end
        else
        begin
            if (por_q && !por_below)
                power_on_reset_flag_q <= 1'b1;
            else if (wr_rstf && !pwdata[`SRW_B_POWER_ON_RESET_FLAG])
                power_on_reset_flag_q <= 1'b0;
            if (!ext_rst_n && !reset_pin_disable_fuse)
                extrf_q <= 1'b1;
            else if (por_below || (wr_rstf && !pwdata[`SRW_B_EXTRF]))
                extrf_q <= 1'b0;
            if (wdt_pulse_q)
                watchdog_reset_flag_q <= 1'b1;
            else if (por_below || (wr_rstf && !pwdata[`SRW_B_WATCHDOG_RESET_FLAG]))
                watchdog_reset_flag_q <= 1'b0;
        end
    end

    // ********************************
    // Watchdog
    // ********************************
    assign wde_eff = wde_q || watchdog_reset_flag_q || watchdog_safety_fuse;
    assign wdt_on = wde_eff || watchdog_irq_enable_q;
    assign prot_ok = (ccp_win_q != 3'h0);
    assign wdt_tmo = wdt_on && osc_tick && !sys_rst && (wdt_cnt_q == wdt_limit(wdp_q));
    assign rst_mode = watchdog_safety_fuse || (wde_eff && (!watchdog_irq_enable_q || wdif_q));
    assign wdt_irq = wdif_q && watchdog_irq_enable_q;

    // Signature opens a four-cycle window
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ccp_win_q <= 3'h0;
        else if (wr_en && reg_hit(paddr, `SRW_IDX_CCP) && pwdata[7:0] == `SRW_CCP_SIG)
            ccp_win_q <= `SRW_CCP_WIN;
        else if (wr_wdt || sys_rst)
            ccp_win_q <= 3'h0;
        else if (prot_ok)
            ccp_win_q <= ccp_win_q - 3'h1;
    end

    // Counter on the oscillator, cleared by instruction, disable, reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wdt_cnt_q <= 20'h0_0000;
        else if (sys_rst || !wdt_on || wdr_instr || wdt_tmo)
            wdt_cnt_q <= 20'h0_0000;
        else if (osc_tick)
            wdt_cnt_q <= wdt_cnt_q + 20'h0_0001;
    end

    // Expiry: reset pulse or interrupt
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wdt_pulse_q <= 1'b0;
        else
            wdt_pulse_q <= wdt_tmo && rst_mode;
    end

    // Control bits with the protected change sequence
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wdif_q <= 1'b0;
            watchdog_irq_enable_q <= 1'b0;
            wde_q <= 1'b0;
            wdp_q <= 4'h0;
        end
        else if (sys_rst)
        begin
            wdif_q <= 1'b0;
            watchdog_irq_enable_q <= 1'b0;
            wde_q <= 1'b0;
            wdp_q <= 4'h0;
        end
        else
        begin
            if (wdt_tmo && !rst_mode)
                wdif_q <= 1'b1;
            else if (wdt_irq_ack || (wr_wdt && pwdata[`SRW_B_WDIF]))
                wdif_q <= 1'b0;
            if (wdt_irq_ack && wde_eff && !watchdog_safety_fuse)
                watchdog_irq_enable_q <= 1'b0;
            else if (wr_wdt)
                watchdog_irq_enable_q <= pwdata[`SRW_B_WATCHDOG_IRQ_ENABLE];
            if (wr_wdt && !watchdog_safety_fuse)
            begin
                wdp_q <= {pwdata[`SRW_B_WDP3], pwdata[2:0]};
                if (pwdata[`SRW_B_WDE])
                    wde_q <= 1'b1;
                else if (prot_ok)
                    wde_q <= 1'b0;
            end
            else if (wr_wdt && prot_ok)
                wdp_q <= {pwdata[`SRW_B_WDP3], pwdata[2:0]};
        end
    end

    // ********************************
    // Checks
    // ********************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sleep_gate_a: assert property ($rose(sleep_q) |-> $past(sleep_instr && sleep_mode_control_se_q))
        else $error("sleep entered without enable");
    adc_gate_a: assert property (wr_en && reg_hit(paddr, `SRW_IDX_PRR) && pwdata[1]
        && !sys_rst |=> !clk_gate.adc_clk_en && !clk_gate.cmp_mux_ok)
        else $error("converter clock not stopped");
    port_reset_a: assert property (src_active |-> !io_reset_n)
        else $error("port reset missed a source");
    delay_hold_a: assert property ($fell(src_active) |-> !core_reset_n [*3])
        else $error("reset not stretched");
    wdt_pulse_a: assert property (wdt_pulse_q |=> !wdt_pulse_q
        && (rs_q == SRW_RS_DELAY || src_active))
        else $error("watchdog pulse not one cycle");
    vlm_clear_a: assert property (vlm_flag_q && !vlm_below |=> !vlm_flag_q)
        else $error("supply flag not cleared");
    wde_forced_a: assert property (watchdog_reset_flag_q |-> wde_eff)
        else $error("enable not forced by flag");
    fuse_reset_a: assert property (watchdog_safety_fuse && wdt_tmo |=> wdt_pulse_q)
        else $error("level 2 expiry did not reset");
    ccp_guard_a: assert property (wr_wdt && !prot_ok && wde_q && !sys_rst
        |=> wde_q)
        else $error("unprotected disable accepted");
    wdr_clear_a: assert property (wdr_instr |=> wdt_cnt_q == 20'h0_0000)
        else $error("watchdog instruction did not clear");

    sleep_c: cover property ($rose(sleep_q));
    wdt_rst_c: cover property (wdt_pulse_q ##1 rs_q == SRW_RS_DELAY);
    vlm_flag_c: cover property ($rose(vlm_flag_q));

endmodule

// file: verilog/srw_cfg.svh
// Offsets, field positions, reset values and counts of the system control block
// Assumes APB byte addresses equal four times the register index
`ifndef SRW_CFG_SVH
`define SRW_CFG_SVH
`define SRW_IDX_WDT 6'h31
`define SRW_IDX_VLM 6'h34
`define SRW_IDX_PRR 6'h35
`define SRW_IDX_SLEEP_MODE_CONTROL 6'h3A
`define SRW_IDX_RSTF 6'h3B
`define SRW_IDX_CCP 6'h3C
`define SRW_CCP_SIG 8'hD8
`define SRW_CCP_WIN 3'h4
`define SRW_WDT_BASE 32'h0000_0800
`define SRW_WDT_MAXP 4'h9
`define SRW_WDT_OSC_KHZ 128
`define SRW_TOUT_OSC_CYC 64
`define SRW_PRR_RST 2'h0
`define SRW_SLEEP_MODE_CONTROL_RST 4'h0
`define SRW_B_WDIF 7
`define SRW_B_WATCHDOG_IRQ_ENABLE 6
`define SRW_B_WDP3 5
`define SRW_B_WDE 3
`define SRW_B_SUPPLY_MONITOR_FLAG 7
`define SRW_B_SUPPLY_MONITOR_IRQ_ENABLE 6
`define SRW_B_WATCHDOG_RESET_FLAG 3
`define SRW_B_EXTRF 1
`define SRW_B_POWER_ON_RESET_FLAG 0
`endif

// file: verilog/srw_pkg.sv
// Types shared by the system control block
// Assumes the constants header is compiled alongside
package srw_pkg;
    typedef enum logic [1:0] {
        SRW_RS_HOLD = 2'b00,
        SRW_RS_DELAY = 2'b01,
        SRW_RS_RUN = 2'b10
    } srw_rst_state_t;
    typedef enum logic [2:0] {
        SRW_SL_IDLE = 3'b000,
        SRW_SL_NOISE = 3'b001,
        SRW_SL_PDOWN = 3'b010,
        SRW_SL_STBY = 3'b100
    } srw_sleep_t;
    typedef struct packed {
        logic adc_clk_en;
        logic tim_clk_en;
        logic cmp_mux_ok;
    } srw_clk_gate_t;
endpackage

// file: testbench/srw_core_model.sv
// Behavioural processor core that issues instruction and event pulses
// Assumes pclk from the bench; every pulse starts right after a rising edge
`timescale 1ns/10ps
module srw_core_model
(
    input wire logic pclk,
    output logic sleep_instr,
    output logic wdr_instr,
    output logic wake_evt,
    output logic wdt_irq_ack
);
    // All pulses idle low until the bench asks for one
    initial
    begin
        {sleep_instr, wdr_instr, wake_evt, wdt_irq_ack} = 4'h0;
    end

    // One-cycle pulse: 0 sleep, 1 watchdog clear, 2 wake, 3 interrupt taken
    task pulse(input int k);
        @(posedge pclk);
        sleep_instr <= (k == 0);
        wdr_instr <= (k == 1);
        wake_evt <= (k == 2);
        wdt_irq_ack <= (k == 3);
        @(posedge pclk);
        {sleep_instr, wdr_instr, wake_evt, wdt_irq_ack} <= 4'h0;
    endtask
endmodule

// file: testbench/srw_sys_ctrl_tb.sv
// Self-checking bench for the system control block over APB
// Assumes the design files, the constants header and the core model
`timescale 1ns/10ps
`include "srw_cfg.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module srw_sys_ctrl_tb;
    import srw_pkg::*;
    // ****************************************
    // Design, core model and clocks
    // ****************************************
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, wdt_osc, err;
    logic por_below, ext_rst_n, vlm_below, pin_fuse, safety_fuse;
    logic sleep_instr, wdr_instr, wake_evt, wdt_irq_ack, io_reset_n;
    logic core_reset_n, sleep_active, wdt_irq, vlm_irq;
    logic [7:0] paddr;
    logic [7:0] rd;
    logic [3:0] pstrb;
    logic [31:0] pwdata, prdata;
    logic [2:0] sleep_mode_out, trig_level;
    logic [1:0] osc_div;
    srw_clk_gate_t clk_gate;
    int bad_count, cmp_count, ticks, n, t0;

    srw_sys_ctrl #(.RESET_TOUT_OSC(2)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .wdt_osc(wdt_osc),
        .por_below(por_below), .ext_rst_n(ext_rst_n), .vlm_below(vlm_below),
        .reset_pin_disable_fuse(pin_fuse), .watchdog_safety_fuse(safety_fuse),
        .sleep_instr(sleep_instr), .wdr_instr(wdr_instr), .wake_evt(wake_evt),
        .wdt_irq_ack(wdt_irq_ack), .io_reset_n(io_reset_n), .core_reset_n(core_reset_n),
        .sleep_active(sleep_active), .sleep_mode_out(sleep_mode_out),
        .supply_trigger_level(trig_level), .clk_gate(clk_gate), .wdt_irq(wdt_irq),
        .vlm_irq(vlm_irq));
    srw_core_model core (.pclk(pclk), .sleep_instr(sleep_instr), .wdr_instr(wdr_instr),
        .wake_evt(wake_evt), .wdt_irq_ack(wdt_irq_ack));

    // System clock, 4 ns period
    always #2 pclk = ~pclk;

    // Fast watchdog oscillator, one tick every four clocks, counted by the bench
    always @(posedge pclk)
    begin
        osc_div <= osc_div + 2'h1;
        wdt_osc <= osc_div[1];
        if (osc_div == 2'h1)
            ticks <= ticks + 1;
    end

    // ****************************************
    // Tasks
    // ****************************************
    task conclude;
        $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Wait-limit exhausted: count it and stop
    task give_up;
        bad_count++;
        $display("Error at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        conclude();
    endtask

    // One APB transfer; byte address is four times the register index
    task apb(input logic wr, input logic [5:0] idx, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (n >= 16)
            give_up();
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic probe(input int w);
        case (w)
            0: return core_reset_n;
            1: return wdt_irq;
            default: return ~core_reset_n;
        endcase
    endfunction

    // Bounded wait until the chosen signal is high at a rising edge
    task wait_hi(input int w, input int lim);
        n = 0;
        while (probe(w) !== 1'b1)
        begin
            @(posedge pclk);
            n++;
            if (n > lim)
                give_up();
        end
    endtask

    // Pin reset (k=0) or power-on reset (k=1), then the matching flag
    task src_reset(input int k);
        @(posedge pclk);
        if (k == 0)
            ext_rst_n <= 1'b0;
        else
            por_below <= 1'b1;
        #1 `CHK(io_reset_n, 1'b0)
        repeat (3) @(posedge pclk);
        ext_rst_n <= 1'b1;
        por_below <= 1'b0;
        @(posedge pclk);
        #1 `CHK(core_reset_n, 1'b0)
        wait_hi(0, 200);
        apb(0, `SRW_IDX_RSTF, 8'h00);
        `CHK(rd[1 - k], 1'b1)
        apb(1, `SRW_IDX_RSTF, 8'h00);
        $display("Test reset source %0d done", k);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    initial
    begin
        {presetn, psel, penable, pwrite, por_below, vlm_below} = 6'h00;
        {pin_fuse, safety_fuse, wdt_osc} = 3'h0;
        ext_rst_n = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        osc_div = 2'h0;
        pstrb = 4'hF;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1 `CHK(core_reset_n, 1'b0)
        wait_hi(0, 200);
        apb(0, `SRW_IDX_PRR, 8'h00);
        `CHK(rd, 8'h00)
        `CHK(clk_gate, 3'b111)
        apb(0, `SRW_IDX_SLEEP_MODE_CONTROL, 8'h00);
        `CHK(rd, 8'h00)
        apb(0, 6'h00, 8'h00);
        `CHK({err, rd}, 9'h100)
        $display("Test reset values done");
        // Clock gating for every combination of the two bits
        for (int i = 3; i >= 0; i--)
        begin
            apb(1, `SRW_IDX_PRR, i[7:0]);
            #1 `CHK(clk_gate, {~i[1], ~i[0], ~i[1]})
            apb(0, `SRW_IDX_PRR, 8'h00);
            `CHK(rd, i[7:0])
        end
        // A write without its low byte strobe leaves the register alone
        pstrb <= 4'hE;
        apb(1, `SRW_IDX_PRR, 8'h03);
        pstrb <= 4'hF;
        apb(0, `SRW_IDX_PRR, 8'h00);
        `CHK(rd, 8'h00)
        $display("Test clock gating done");
        // Every sleep code with enable set, then the enable clear
        for (int m = 0; m < 8; m++)
        begin
            apb(1, `SRW_IDX_SLEEP_MODE_CONTROL, {4'h0, m[2:0], 1'b1});
            core.pulse(0);
            #1 `CHK(sleep_active, 1'(m inside {0, 1, 2, 4}))
            `CHK(sleep_mode_out, m[2:0])
            core.pulse(2);
            apb(1, `SRW_IDX_SLEEP_MODE_CONTROL, 8'h00);
        end
        core.pulse(0);
        #1 `CHK(sleep_active, 1'b0)
        $display("Test sleep done");
        src_reset(0);
        src_reset(1);
        // Pin ignored while its disable fuse is programmed
        pin_fuse <= 1'b1;
        ext_rst_n <= 1'b0;
        repeat (3) @(posedge pclk);
        #1 `CHK({io_reset_n, core_reset_n}, 2'b11)
        ext_rst_n <= 1'b1;
        pin_fuse <= 1'b0;
        // Supply monitor flag, interrupt, clears, and reset level
        apb(1, `SRW_IDX_VLM, 8'h43);
        vlm_below <= 1'b1;
        repeat (3) @(posedge pclk);
        #1 `CHK({vlm_irq, trig_level}, 4'hB)
        apb(0, `SRW_IDX_VLM, 8'h00);
        `CHK(rd, 8'hC3)
        apb(1, `SRW_IDX_VLM, 8'h43);
        apb(0, `SRW_IDX_VLM, 8'h00);
        `CHK(rd, 8'h43)
        vlm_below <= 1'b0;
        apb(1, `SRW_IDX_VLM, 8'h01);
        vlm_below <= 1'b1;
        repeat (20) @(posedge pclk);
        #1 `CHK(core_reset_n, 1'b0)
        vlm_below <= 1'b0;
        wait_hi(0, 200);
        apb(1, `SRW_IDX_VLM, 8'h00);
        // Second flag level: set on a falling supply, cleared on recovery
        apb(1, `SRW_IDX_VLM, 8'h04);
        vlm_below <= 1'b1;
        apb(0, `SRW_IDX_VLM, 8'h00);
        `CHK(rd, 8'h84)
        vlm_below <= 1'b0;
        apb(0, `SRW_IDX_VLM, 8'h00);
        `CHK(rd, 8'h04)
        apb(1, `SRW_IDX_VLM, 8'h00);
        $display("Test supply monitor done");
        // Interrupt mode; a clear instruction restarts the count
        apb(1, `SRW_IDX_WDT, 8'h40);
        repeat (4000) @(posedge pclk);
        core.pulse(1);
        t0 = ticks;
        wait_hi(1, 9000);
        `CHK(1'((ticks - t0) inside {[2046:2050]}), 1'b1)
        core.pulse(3);
        #1 `CHK(wdt_irq, 1'b0)
        apb(1, `SRW_IDX_WDT, 8'h00);
        // Reset mode expiry, flag, forced enable, protected disable
        apb(1, `SRW_IDX_WDT, 8'h08);
        t0 = ticks;
        wait_hi(2, 9000);
        `CHK(1'((ticks - t0) inside {[2046:2050]}), 1'b1)
        wait_hi(0, 200);
        apb(0, `SRW_IDX_RSTF, 8'h00);
        `CHK(rd[3], 1'b1)
        apb(0, `SRW_IDX_WDT, 8'h00);
        `CHK(rd[3], 1'b1)
        apb(1, `SRW_IDX_RSTF, 8'h00);
        apb(1, `SRW_IDX_WDT, 8'h08);
        apb(1, `SRW_IDX_WDT, 8'h00);
        apb(0, `SRW_IDX_WDT, 8'h00);
        `CHK(rd[3], 1'b1)
        apb(1, `SRW_IDX_CCP, `SRW_CCP_SIG);
        apb(1, `SRW_IDX_WDT, 8'h00);
        apb(0, `SRW_IDX_WDT, 8'h00);
        `CHK(rd[3], 1'b0)
        $display("Test watchdog level one done");
        // Safety level two: always on, period change needs the signature
        safety_fuse <= 1'b1;
        apb(1, `SRW_IDX_WDT, 8'h01);
        apb(0, `SRW_IDX_WDT, 8'h00);
        `CHK(rd, 8'h08)
        apb(1, `SRW_IDX_CCP, `SRW_CCP_SIG);
        apb(1, `SRW_IDX_WDT, 8'h01);
        apb(0, `SRW_IDX_WDT, 8'h00);
        `CHK(rd, 8'h09)
        // Level two expiry always resets; period code 0001 doubles the count
        core.pulse(1);
        t0 = ticks;
        wait_hi(2, 18000);
        `CHK(1'((ticks - t0) inside {[4094:4098]}), 1'b1)
        wait_hi(0, 200);
        apb(0, `SRW_IDX_RSTF, 8'h00);
        `CHK(rd[3], 1'b1)
        apb(1, `SRW_IDX_RSTF, 8'h00);
        safety_fuse <= 1'b0;
        apb(1, `SRW_IDX_CCP, `SRW_CCP_SIG);
        apb(1, `SRW_IDX_WDT, 8'h00);
        $display("Test watchdog level two done");
        // Both bits: first expiry interrupts, the taken interrupt arms the reset
        apb(1, `SRW_IDX_WDT, 8'h48);
        t0 = ticks;
        wait_hi(1, 9000);
        core.pulse(3);
        #1 `CHK(wdt_irq, 1'b0)
        apb(0, `SRW_IDX_WDT, 8'h00);
        `CHK(rd, 8'h08)
        wait_hi(2, 9000);
        `CHK(1'((ticks - t0) inside {[4094:4098]}), 1'b1)
        wait_hi(0, 200);
        apb(1, `SRW_IDX_RSTF, 8'h00);
        $display("Test watchdog both modes done");
        conclude();
    end
endmodule
